// File: common/irq_arb_params.svh
`ifndef IRQ_ARB_PARAMS_SVH
`define IRQ_ARB_PARAMS_SVH

// request nodes and arbitration key widths
`define IRQ_NODES 128
`define IRQ_EXT_GROUP_MIN 64
`define IRQ_IDX_W 7
`define IRQ_KEY_W 7
`define XFER_DONE_LINE 7'h7f

// per-source control register fields
`define CTRL_GRP_EXT_BIT 8
`define CTRL_FLAG_BIT 7
`define CTRL_EN_BIT 6
`define CTRL_LVL_HI 5
`define CTRL_LVL_LO 2
`define CTRL_GRP_HI 1
`define CTRL_GRP_LO 0
`define CTRL_RESET 9'h000

// register word indices (byte address is four times the index)
`define REG_CTRL_FIRST 8'h00
`define REG_CTRL_LAST 8'h7f
`define REG_XFER_SEL_FIRST 8'h80
`define REG_XFER_SEL_LAST 8'h83
`define REG_STATUS 8'h84
`define XFER_SEL_RESET 32'h0000_0000

// action kinds presented to the cpu
`define KIND_IRQ 2'h0
`define KIND_XFER 2'h1
`define KIND_DEBUG 2'h2

`endif

// File: common/irq_arb_pkg.sv
package irq_arb_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_RANK  = 3'b010,
        ST_OFFER = 3'b100
    } arb_state_t;

    typedef logic [1:0] action_kind_t;

endpackage

// File: common/winner_if.sv
`timescale 1ns/1ps

interface winner_if;
    logic irq_valid;
    logic [6:0] irq_idx;
    logic [3:0] irq_level;
    logic irq_xfer;
    logic dbg_valid;
    logic [4:0] dbg_prio;
    logic [3:0] cpu_level;
    logic cpu_ien;
    logic accept;
    logic [4:0] out_prio;
    irq_arb_pkg::action_kind_t out_kind;

    modport arb
    (
        output irq_valid, irq_idx, irq_level, irq_xfer, dbg_valid, dbg_prio,
        output cpu_level, cpu_ien,
        input accept, out_prio, out_kind
    );
    modport dec
    (
        input irq_valid, irq_idx, irq_level, irq_xfer, dbg_valid, dbg_prio,
        input cpu_level, cpu_ien,
        output accept, out_prio, out_kind
    );
endinterface

// File: src/cand_max.sv
`timescale 1ns/1ps
`include "irq_arb_params.svh"

module cand_max
(
    // first candidate
    input wire logic a_valid_i,
    input wire logic [`IRQ_KEY_W-1:0] a_key_i,
    input wire logic [`IRQ_IDX_W-1:0] a_idx_i,
    // second candidate
    input wire logic b_valid_i,
    input wire logic [`IRQ_KEY_W-1:0] b_key_i,
    input wire logic [`IRQ_IDX_W-1:0] b_idx_i,
    // winner
    output logic valid_o,
    output logic [`IRQ_KEY_W-1:0] key_o,
    output logic [`IRQ_IDX_W-1:0] idx_o
);
    logic take_a;

    // equal keys only arise from a software setup error; lower index then wins
    assign take_a = a_valid_i && (!b_valid_i || (a_key_i >= b_key_i));
    assign valid_o = a_valid_i || b_valid_i;
    assign key_o = take_a ? a_key_i : b_key_i;
    assign idx_o = take_a ? a_idx_i : b_idx_i;
endmodule

// File: src/irq_prio_arbiter.sv
// Contract
// - up to 128 nodes, eight groups above 64
// - hardware event sets its source request flag
// - software setting the flag raises a request
// - pending enabled request starts round next cycle
// - requests raised mid-round wait for next round
// - cpu acceptance clears the winning source flag
// - round compares snapshot, independent of timing
// - arbitrate while pending, idle otherwise
// - first stage compares level and group level
// - extension bit tops a 3-bit group level
// - debug skips stage one, group ignored
// - request level zero-extended; debug top bit wins
// - debug tie with top bit clear loses
// - accept above cpu level, irq needs enable
// - global enable clear refuses levels 0 to 15
// - cpu level zero-extended; top bit always interrupts
// - refused requests stay pending, flag kept
// - level zero arbitrated but never accepted
// - any enabled request wakes cpu regardless
// - debug break and traps bypass arbitration
// - transfer completion drives one request line
// - winner presented with level and action kind
// - control register bit layout, upper bits zero
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "irq_arb_params.svh"

module irq_prio_arbiter
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // request sources
    input wire logic [`IRQ_NODES-1:0] src_event_i,
    input wire logic xfer_done_i,
    // debug service request
    input wire logic dbg_req_i,
    input wire logic [4:0] dbg_prio_i,
    // cpu status word
    input wire logic [3:0] cpu_level_i,
    input wire logic global_irq_enable_i,
    // cpu action interface
    input wire logic cpu_accept_i,
    output logic act_valid_o,
    output logic [`IRQ_IDX_W-1:0] act_src_o,
    output logic [4:0] act_prio_o,
    output logic [1:0] act_kind_o,
    output logic cpu_wake_o,
    output logic arb_idle_o,
    // bypass paths
    input wire logic dbg_break_i,
    input wire logic hw_trap_i,
    output logic dbg_break_o,
    output logic hw_trap_o
);
    localparam int N = `IRQ_NODES;

    ////////////////////////////////////////////////////////////////////////////
    // storage and bus decode

    logic [8:0] ctrl_q [N];
    logic [N-1:0] xfer_sel_q;
    logic ack_q;
    logic [31:0] rdat_q;
    irq_arb_pkg::arb_state_t state_q;
    logic [N-1:0] snap_q;
    logic snap_dbg_q;
    logic [4:0] snap_dbg_prio_q;
    logic win_valid_q;
    logic [`IRQ_IDX_W-1:0] win_idx_q;
    logic [3:0] win_level_q;
    logic win_xfer_q;
    logic act_valid_q;
    logic [`IRQ_IDX_W-1:0] act_src_q;
    logic [4:0] act_prio_q;
    logic [1:0] act_kind_q;
    logic wake_q;
    logic dbg_break_q;
    logic hw_trap_q;

    logic [7:0] word_idx;
    logic bus_req;
    logic wr_strobe;
    logic [N-1:0] hw_set;
    logic [N-1:0] pending;
    logic any_pending;
    logic ack_clear;

    assign word_idx = adr_i[9:2];
    assign bus_req = cyc_i && stb_i;
    // a write lands at the edge where the master samples ack high
    assign wr_strobe = ack_q && bus_req && we_i;

    always_comb
    begin
        hw_set = src_event_i;
        hw_set[`XFER_DONE_LINE] = src_event_i[`XFER_DONE_LINE] | xfer_done_i;
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_pend
            assign pending[g] = ctrl_q[g][`CTRL_FLAG_BIT] && ctrl_q[g][`CTRL_EN_BIT];
        end
    endgenerate

    assign any_pending = |pending;
    assign ack_clear = (state_q == irq_arb_pkg::ST_OFFER) && act_valid_q && cpu_accept_i
        && (act_kind_q != `KIND_DEBUG);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone handshake: ack one cycle after the request, dropped after one

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= bus_req && !ack_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_q <= 32'h0000_0000;
        end
        else if (bus_req && !ack_q)
        begin
            rdat_q <= 32'h0000_0000;
            if (word_idx <= `REG_CTRL_LAST)
            begin
                rdat_q <= {23'h000000, ctrl_q[word_idx[6:0]]};
            end
            else if (word_idx <= `REG_XFER_SEL_LAST)
            begin
                rdat_q <= xfer_sel_q[word_idx[1:0]*32 +: 32];
            end
            else if (word_idx == `REG_STATUS)
            begin
                rdat_q <= {14'h0000, act_kind_q, act_prio_q, act_src_q, act_valid_q,
                    state_q};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-source control registers

    generate
        for (g = 0; g < N; g++)
        begin : g_ctrl
            logic wr_hit;
            logic [8:0] wr_val;

            assign wr_hit = wr_strobe && (word_idx == 8'(g));
            always_comb
            begin
                wr_val = ctrl_q[g];
                if (sel_i[0])
                begin
                    wr_val[7:0] = dat_i[7:0];
                end
                if (sel_i[1])
                begin
                    wr_val[8] = dat_i[8];
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    ctrl_q[g] <= `CTRL_RESET;
                end
                else
                begin
                    if (wr_hit)
                    begin
                        ctrl_q[g] <= wr_val;
                    end
                    if (ack_clear && (act_src_q == 7'(g)))
                    begin
                        ctrl_q[g][`CTRL_FLAG_BIT] <= 1'b0;
                    end
                    // an event in the same cycle as a clear is not lost
                    if (hw_set[g])
                    begin
                        ctrl_q[g][`CTRL_FLAG_BIT] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xfer_sel_q <= {4{`XFER_SEL_RESET}};
        end
        else if (wr_strobe && (word_idx >= `REG_XFER_SEL_FIRST)
            && (word_idx <= `REG_XFER_SEL_LAST))
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (sel_i[b])
                begin
                    xfer_sel_q[word_idx[1:0]*32 + b*8 +: 8] <= dat_i[b*8 +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // first stage: comparator tree over the round snapshot

    logic node_valid [1:2*N-1];
    logic [`IRQ_KEY_W-1:0] node_key [1:2*N-1];
    logic [`IRQ_IDX_W-1:0] node_idx [1:2*N-1];

    generate
        for (g = 0; g < N; g++)
        begin : g_leaf
            logic [2:0] grp;

            // at or below the node threshold the extension bit takes no part
            assign grp = (N > `IRQ_EXT_GROUP_MIN)
                ? {ctrl_q[g][`CTRL_GRP_EXT_BIT], ctrl_q[g][`CTRL_GRP_HI:`CTRL_GRP_LO]}
                : {1'b0, ctrl_q[g][`CTRL_GRP_HI:`CTRL_GRP_LO]};
            assign node_valid[N+g] = snap_q[g];
            assign node_key[N+g] = {ctrl_q[g][`CTRL_LVL_HI:`CTRL_LVL_LO], grp};
            assign node_idx[N+g] = 7'(g);
        end
        for (g = 1; g < N; g++)
        begin : g_node
            cand_max u_cmp
            (
                .a_valid_i(node_valid[2*g]),
                .a_key_i(node_key[2*g]),
                .a_idx_i(node_idx[2*g]),
                .b_valid_i(node_valid[2*g+1]),
                .b_key_i(node_key[2*g+1]),
                .b_idx_i(node_idx[2*g+1]),
                .valid_o(node_valid[g]),
                .key_o(node_key[g]),
                .idx_o(node_idx[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // second and third stage

    winner_if win ();

    assign win.irq_valid = win_valid_q;
    assign win.irq_idx = win_idx_q;
    assign win.irq_level = win_level_q;
    assign win.irq_xfer = win_xfer_q;
    assign win.dbg_valid = snap_dbg_q;
    assign win.dbg_prio = snap_dbg_prio_q;
    assign win.cpu_level = cpu_level_i;
    assign win.cpu_ien = global_irq_enable_i;

    stage_decide u_decide
    (
        .w(win.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // round sequencing

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= irq_arb_pkg::ST_IDLE;
            snap_q <= '0;
            snap_dbg_q <= 1'b0;
            snap_dbg_prio_q <= 5'h00;
        end
        else
        begin
            unique case (state_q)
                irq_arb_pkg::ST_IDLE:
                begin
                    // only the requests seen here join; later ones wait
                    if (any_pending || dbg_req_i)
                    begin
                        state_q <= irq_arb_pkg::ST_RANK;
                        snap_q <= pending;
                        snap_dbg_q <= dbg_req_i;
                        snap_dbg_prio_q <= dbg_prio_i;
                    end
                end
                irq_arb_pkg::ST_RANK:
                begin
                    state_q <= irq_arb_pkg::ST_OFFER;
                end
                irq_arb_pkg::ST_OFFER:
                begin
                    // a refused winner ends the round; its flag stays set
                    if (!win.accept || (act_valid_q && cpu_accept_i))
                    begin
                        state_q <= irq_arb_pkg::ST_IDLE;
                        snap_q <= '0;
                        snap_dbg_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            win_valid_q <= 1'b0;
            win_idx_q <= 7'h00;
            win_level_q <= 4'h0;
            win_xfer_q <= 1'b0;
        end
        else if (state_q == irq_arb_pkg::ST_RANK)
        begin
            win_valid_q <= node_valid[1];
            win_idx_q <= node_idx[1];
            win_level_q <= node_key[1][`IRQ_KEY_W-1:3];
            win_xfer_q <= xfer_sel_q[node_idx[1]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu action outputs

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            act_valid_q <= 1'b0;
            act_src_q <= 7'h00;
            act_prio_q <= 5'h00;
            act_kind_q <= `KIND_IRQ;
        end
        else if ((state_q == irq_arb_pkg::ST_OFFER) && win.accept
            && !(act_valid_q && cpu_accept_i))
        begin
            act_valid_q <= 1'b1;
            act_src_q <= win.irq_idx;
            act_prio_q <= win.out_prio;
            act_kind_q <= win.out_kind;
        end
        else
        begin
            // withdrawn when taken or when the cpu level overtakes it
            act_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wake_q <= 1'b0;
            dbg_break_q <= 1'b0;
            hw_trap_q <= 1'b0;
        end
        else
        begin
            wake_q <= any_pending;
            dbg_break_q <= dbg_break_i;
            hw_trap_q <= hw_trap_i;
        end
    end

    assign dat_o = rdat_q;
    assign ack_o = ack_q;
    assign act_valid_o = act_valid_q;
    assign act_src_o = act_src_q;
    assign act_prio_o = act_prio_q;
    assign act_kind_o = act_kind_q;
    assign cpu_wake_o = wake_q;
    assign arb_idle_o = state_q[0]; // one-hot idle bit, straight from the flop
    assign dbg_break_o = dbg_break_q;
    assign hw_trap_o = hw_trap_q;
endmodule

// File: src/stage_decide.sv
`timescale 1ns/1ps
`include "irq_arb_params.svh"

module stage_decide
(
    winner_if.dec w
);
    logic [4:0] irq_prio;
    logic dbg_wins;
    logic [4:0] cpu_prio;

    assign irq_prio = {1'b0, w.irq_level};
    // group level is ignored here; a tie goes to the interrupt side
    assign dbg_wins = w.dbg_valid && (!w.irq_valid || (w.dbg_prio > irq_prio));
    assign w.out_prio = dbg_wins ? w.dbg_prio : irq_prio;
    assign w.out_kind = dbg_wins ? `KIND_DEBUG : (w.irq_xfer ? `KIND_XFER : `KIND_IRQ);
    assign cpu_prio = {1'b0, w.cpu_level};

    always_comb
    begin
        if (dbg_wins)
        begin
            w.accept = w.out_prio > cpu_prio;
        end
        else
        begin
            // level zero never exceeds the cpu default level, checked explicitly anyway
            w.accept = w.irq_valid && w.cpu_ien && (w.irq_level != 4'h0)
                && (irq_prio > cpu_prio);
        end
    end
endmodule

// File: verification/cpu_action_model.sv
`timescale 1ns/1ps

module cpu_action_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // offer and response speed
    input wire logic act_valid_i,
    input wire logic [3:0] delay_i,
    // acceptance
    output logic accept_o
);
    logic [3:0] wait_q;
    // one-cycle take once the offer has stood delay_i cycles; reset on take avoids a double take
    assign accept_o = act_valid_i && wait_q >= delay_i;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !act_valid_i || accept_o)
            wait_q <= 4'h0;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule

// File: verification/interrupt_priority_arbiter_tb.sv
`timescale 1ns/1ps
`include "irq_arb_params.svh"

module interrupt_priority_arbiter_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [127:0] src_event_i = '0;
    logic xfer_done_i = 1'b0;
    logic dbg_req_i = 1'b0;
    logic [4:0] dbg_prio_i = 5'h00;
    logic [3:0] cpu_level_i = 4'h0;
    logic global_irq_enable_i = 1'b1;
    logic dbg_break_i = 1'b0;
    logic hw_trap_i = 1'b0;
    logic [3:0] delay = 4'h0;
    logic [31:0] dat_o;
    logic [6:0] act_src_o;
    logic [4:0] act_prio_o;
    logic [1:0] act_kind_o;
    logic ack_o, cpu_accept_i, act_valid_o, cpu_wake_o, arb_idle_o, dbg_break_o, hw_trap_o;
    int failures = 0;
    int compares = 0;

    irq_prio_arbiter DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .src_event_i, .xfer_done_i, .dbg_req_i, .dbg_prio_i, .cpu_level_i,
        .global_irq_enable_i, .cpu_accept_i, .act_valid_o, .act_src_o, .act_prio_o,
        .act_kind_o, .cpu_wake_o, .arb_idle_o, .dbg_break_i, .hw_trap_i, .dbg_break_o, .hw_trap_o);
    cpu_action_model cpu (.clk_i, .rst_i, .act_valid_i(act_valid_o), .delay_i(delay),
        .accept_o(cpu_accept_i));

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] ctrl(logic f, logic e, logic [3:0] l, logic [2:0] g);
        return {23'h0, g[2], f, e, l, g[1:0]};
    endfunction

    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {22'h0, idx, 2'b00};
        dat_i <= d;
        // the watchdog ends a wait for an answer that never comes
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // first cycle v1, second cycle v2 and the debug request, so that a debug
    // request meets the flag set by v1 in one round
    task automatic fire(input logic [127:0] v1, input logic [127:0] v2, input logic x,
        input logic d);
        @(posedge clk_i);
        src_event_i <= v1;
        xfer_done_i <= x;
        @(posedge clk_i);
        src_event_i <= v2;
        xfer_done_i <= 1'b0;
        dbg_req_i <= d;
        @(posedge clk_i);
        src_event_i <= '0;
    endtask

    task automatic wait_offer(input int lim, output logic got);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++)
        begin
            @(posedge clk_i);
            got = act_valid_o === 1'b1;
        end
    endtask

    task automatic expect_offer(input logic [6:0] src, input logic [4:0] prio,
        input logic [1:0] kind);
        logic got;
        wait_offer(12, got);
        dbg_req_i <= 1'b0;
        check("offer", got, 1'b1);
        if (kind !== `KIND_DEBUG)
            check("source", act_src_o, src);
        check("priority", act_prio_o, prio);
        check("kind", act_kind_o, kind);
        while (act_valid_o === 1'b1)
            @(posedge clk_i);
    endtask

    initial
    begin
        logic [31:0] r, w;
        logic [127:0] ev;
        logic [6:0] s[3];
        logic [3:0] l[3];
        logic [2:0] g[3];
        logic done[3];
        logic got;
        int b;
        void'($urandom(32'he71b7158));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `REG_STATUS, 0, r);
        check("status", r, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            b = $urandom_range(127, 0);
            wb(0, b[7:0], 0, r);
            check("ctrl reset", r, 32'h0);
            w = $urandom() & 32'hffff_ffbf;
            l[1] = 4'($urandom());
            sel_i <= l[1];
            wb(1, b[7:0], w, r);
            sel_i <= 4'hf;
            wb(0, b[7:0], 0, r);
            check("ctrl layout", r, w & {23'h0, l[1][1], {8{l[1][0]}}});
            wb(1, b[7:0], 0, r);
        end
        wb(1, 8'hc3, 32'hffff_ffff, r);
        wb(0, 8'hc3, 0, r);
        check("unmapped", r, 32'h0);
        // odd rounds are transfer services; software, hardware and completion raise them
        for (int i = 0; i < 8; i++)
        begin
            b = (i == 7) ? 127 : $urandom_range(126, 0);
            l[0] = 4'($urandom_range(15, 1));
            delay <= 4'($urandom_range(4, 0));
            wb(1, 8'h80 + {6'h0, b[6:5]}, (i % 2) << b[4:0], r);
            wb(1, b[7:0], ctrl(i < 3, 1, l[0], 3'h0), r);
            if (i >= 3)
                fire((i < 7) ? (128'h1 << b) : '0, '0, i == 7, 0);
            expect_offer(b[6:0], {1'b0, l[0]},
                (i % 2) ? `KIND_XFER : `KIND_IRQ);
            wb(0, b[7:0], 0, r);
            check("flag cleared", r, ctrl(0, 1, l[0], 3'h0));
            wb(1, b[7:0], 0, r);
            wb(1, 8'h80 + {6'h0, b[6:5]}, 0, r);
        end
        for (int t = 0; t < 4; t++)
        begin
            ev = '0;
            w = $urandom();
            for (int i = 0; i < 3; i++)
            begin
                s[i] = 7'(i * 40 + $urandom_range(39, 0));
                l[i] = 4'($urandom_range(15, 1));
                g[i] = w[2:0] + 3'(i * 3);
                done[i] = 1'b0;
                wb(1, {1'b0, s[i]}, ctrl(0, 1, l[i], g[i]), r);
                ev[s[i]] = 1'b1;
            end
            fire(ev, '0, 0, 0);
            for (int k = 0; k < 3; k++)
            begin
                b = -1;
                for (int i = 0; i < 3; i++)
                    if (!done[i] && (b < 0 || {l[i], g[i]} > {l[b], g[b]}))
                        b = i;
                done[b] = 1'b1;
                expect_offer(s[b], {1'b0, l[b]}, `KIND_IRQ);
            end
            for (int i = 0; i < 3; i++)
                wb(1, {1'b0, s[i]}, 0, r);
        end
        wb(1, 8'h10, ctrl(0, 1, 4'h2, 3'h0), r);
        wb(1, 8'h20, ctrl(0, 1, 4'hd, 3'h0), r);
        fire(128'h1 << 16, 128'h1 << 32, 0, 0);
        expect_offer(7'h10, 5'h02, `KIND_IRQ);
        expect_offer(7'h20, 5'h0d, `KIND_IRQ);
        // refused cases: level zero, enable off, equal level, lower level
        for (int i = 0; i < 4; i++)
        begin
            l[0] = (i == 0) ? 4'h0 : 4'h5;
            cpu_level_i <= (i == 2) ? 4'h5 : (i == 3) ? 4'h7 : 4'h0;
            global_irq_enable_i <= i != 1;
            wb(1, 8'h09, ctrl(1, 1, l[0], 3'h2), r);
            wait_offer(10, got);
            check("refused", got, 1'b0);
            check("wake", cpu_wake_o, 1'b1);
            wb(0, 8'h09, 0, r);
            check("flag kept", r, ctrl(1, 1, l[0], 3'h2));
            cpu_level_i <= 4'h0;
            global_irq_enable_i <= 1'b1;
            if (i != 0)
                expect_offer(7'h09, 5'h05, `KIND_IRQ);
            wb(1, 8'h09, 0, r);
        end
        for (int i = 0; i < 4; i++)
        begin
            w = (i == 0) ? 32'h16 : (i == 1) ? 32'h06 : (i == 2) ? 32'h07 : 32'h05;
            dbg_prio_i <= w[4:0];
            wb(1, 8'h03, ctrl(0, 1, 4'h6, 3'h7), r);
            fire(128'h1 << 3, '0, 0, 1);
            if (w[4:0] > 5'h06)
                expect_offer(7'h03, w[4:0], `KIND_DEBUG);
            expect_offer(7'h03, 5'h06, `KIND_IRQ);
            wb(1, 8'h03, 0, r);
        end
        repeat (5) @(posedge clk_i);
        check("idle", arb_idle_o, 1'b1);
        check("no wake", cpu_wake_o, 1'b0);
        wrap_up();
    end

    // outputs lag the inputs by one edge; prev holds what should show now
    initial
    begin
        logic [1:0] prev;
        @(negedge rst_i);
        prev = 2'b00;
        forever
        begin
            @(posedge clk_i);
            check("bypass", {dbg_break_o, hw_trap_o}, prev);
            prev = {dbg_break_i, hw_trap_i};
            {dbg_break_i, hw_trap_i} <= 2'($urandom());
        end
    end

    // the whole sequence needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        wrap_up();
    end
endmodule

// File: verification/irq_prio_arbiter_sva.sv
`timescale 1ns/1ps
`include "irq_arb_params.svh"

module irq_prio_arbiter_sva
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // arbitration
    input wire logic dbg_req_i,
    input wire logic [3:0] cpu_level_i,
    input wire logic global_irq_enable_i,
    input wire logic cpu_accept_i,
    input wire logic act_valid_o,
    input wire logic [6:0] act_src_o,
    input wire logic [4:0] act_prio_o,
    input wire logic [1:0] act_kind_o,
    input wire logic cpu_wake_o,
    input wire logic arb_idle_o,
    // bypass
    input wire logic dbg_break_i,
    input wire logic hw_trap_i,
    input wire logic dbg_break_o,
    input wire logic hw_trap_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic irq_offer;
    assign irq_offer = act_valid_o && act_kind_o != `KIND_IRQ + 2'h2;

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered in one cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack stood longer than one cycle");
    AST_UNMAPPED_ZERO: assert property (ack_o && !$past(we_i)
        && $past(adr_i[9:2]) > 8'h84 |-> dat_o == 32'h0)
        else $error("unmapped read returned data");
    AST_DEBUG_STARTS: assert property (arb_idle_o && dbg_req_i |=> !arb_idle_o)
        else $error("round did not start after a request");
    AST_ACCEPT_ENDS: assert property (act_valid_o && cpu_accept_i |=> !act_valid_o)
        else $error("offer stood after acceptance");
    AST_OFFER_HOLDS: assert property (irq_offer && !cpu_accept_i
        && $stable(cpu_level_i) && $stable(global_irq_enable_i)
        |=> act_valid_o && $stable(act_src_o) && $stable(act_prio_o))
        else $error("offer changed while waiting");
    AST_ABOVE_CPU: assert property (act_valid_o && $stable(cpu_level_i)
        |-> act_prio_o > {1'b0, cpu_level_i})
        else $error("offer not above cpu level");
    AST_IRQ_ENABLED: assert property (irq_offer
        && $stable(global_irq_enable_i) |-> global_irq_enable_i && !act_prio_o[4])
        else $error("interrupt offered while disabled");
    AST_LEVEL_ZERO: assert property (act_valid_o |-> act_prio_o != 5'h00)
        else $error("level zero offered");
    AST_WAKE: assert property (irq_offer |-> cpu_wake_o)
        else $error("no wake while request pending");
    AST_BYPASS: assert property (!rst_i
        |=> {dbg_break_o, hw_trap_o} == $past({dbg_break_i, hw_trap_i}))
        else $error("bypass path delay wrong");

    COV_IRQ_TAKEN: cover property (irq_offer && cpu_accept_i);
    COV_DEBUG: cover property (act_valid_o && act_kind_o == `KIND_DEBUG);
    COV_XFER: cover property (act_valid_o && act_kind_o == `KIND_XFER);
endmodule

bind irq_prio_arbiter irq_prio_arbiter_sva chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_o, .ack_o, .dbg_req_i, .cpu_level_i, .global_irq_enable_i, .cpu_accept_i, .act_valid_o,
    .act_src_o, .act_prio_o, .act_kind_o, .cpu_wake_o, .arb_idle_o, .dbg_break_i, .hw_trap_i,
    .dbg_break_o, .hw_trap_o);
